//--- lirq_bank.v
// Interrupt enables, tone status and indirect access port of the line device
//
// Function
// - Enable-2 bits 7..2 gate six power alarm irqs, bit 7 highest.
// - Enable-2 bit 1 gates loop closure transition irq.
// - Enable-2 bit 0 gates ring trip irq.
// - Enable-3 bit 2 gates calibration error irq; bits 7..3 read zero.
// - Enable-3 bit 1 gates indirect access done irq.
// - Enable-3 bit 0 gates tone detected irq.
// - Tone status bit 4 shows digit detection; bits 7..5 read zero.
// - Tone status bits 3..0 show the key code.
// - Sixteen bit indirect data word in low and high bytes; low resets 0.
// - Data then address write stores data at next 16 kHz tick.
// - Address-only write loads data word at next tick.
// - Eight bit address register; writing it starts the transfer.
// - Indirect status bit 0 shows access pending; bits 7..1 zero.
// - Pending flags cleared by writing 1; read 1 while pending.
// - Indirect done flag set when a pending access completes.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "lirq_consts.vh"

module lirq_bank #(
    parameter TICK_CYC = `LIRQ_TICK_CYC,
    parameter AW = 8
) (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    input wire [7:0] alarm_evt,
    input wire calib_err_evt,
    input wire tone_detect_evt,
    input wire digit_detect_flag,
    input wire [3:0] decoded_key_code,
    output reg ind_wr_stb,
    output reg ind_rd_stb,
    output reg [AW-1:0] ind_addr,
    output reg [15:0] ind_wdata,
    input wire [15:0] ind_rdata,
    output wire irq_n
);

////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 2'b01;
localparam ST_PEND = 2'b10;
localparam NFLAG = 11;
localparam SEL_S2 = 0;
localparam SEL_S3 = 1;
localparam SEL_EN2 = 2;
localparam SEL_EN3 = 3;
localparam SEL_TONE = 4;
localparam SEL_DLO = 5;
localparam SEL_DHI = 6;
localparam SEL_LOC = 7;
localparam SEL_STATE = 8;

reg [7:0] en2_reg;
reg [7:0] en2_next;
reg [2:0] en3_reg;
reg [2:0] en3_next;
reg [15:0] tick_cnt_reg;
reg [15:0] tick_cnt_next;
reg [1:0] state_reg;
reg [1:0] state_next;
reg [15:0] indirect_data_word_reg;
reg [15:0] indirect_data_word_next;
reg [7:0] indirect_location_reg;
reg [7:0] indirect_location_next;
reg dirty_reg;
reg dirty_next;
reg done_pulse_reg;
reg [7:0] rdata_next;
reg [8:0] sel_vec;
wire tick;
wire wr_en2;
wire wr_en3;
wire wr_s2;
wire wr_s3;
wire wr_lo;
wire wr_hi;
wire wr_loc;
wire indirect_pending_flag;
wire complete;
wire [NFLAG-1:0] evt_all;
wire [NFLAG-1:0] clr_all;
wire [NFLAG-1:0] en_all;
wire [NFLAG-1:0] flag_all;
wire [NFLAG-1:0] gated_all;

// Register select, one bit per mapped offset
always @* begin
    sel_vec = 9'h000;
    if (addr == `LIRQ_OFF_STAT2) begin
        sel_vec[SEL_S2] = 1'b1;
    end else if (addr == `LIRQ_OFF_STAT3) begin
        sel_vec[SEL_S3] = 1'b1;
    end else if (addr == `LIRQ_OFF_EN2) begin
        sel_vec[SEL_EN2] = 1'b1;
    end else if (addr == `LIRQ_OFF_EN3) begin
        sel_vec[SEL_EN3] = 1'b1;
    end else if (addr == `LIRQ_OFF_TONE) begin
        sel_vec[SEL_TONE] = 1'b1;
    end else if (addr == `LIRQ_OFF_DLO) begin
        sel_vec[SEL_DLO] = 1'b1;
    end else if (addr == `LIRQ_OFF_DHI) begin
        sel_vec[SEL_DHI] = 1'b1;
    end else if (addr == `LIRQ_OFF_LOC) begin
        sel_vec[SEL_LOC] = 1'b1;
    end else if (addr == `LIRQ_OFF_STATE) begin
        sel_vec[SEL_STATE] = 1'b1;
    end
end

assign wr_en2 = wr_stb && sel_vec[SEL_EN2];
assign wr_en3 = wr_stb && sel_vec[SEL_EN3];
assign wr_s2 = wr_stb && sel_vec[SEL_S2];
assign wr_s3 = wr_stb && sel_vec[SEL_S3];
assign wr_lo = wr_stb && sel_vec[SEL_DLO];
assign wr_hi = wr_stb && sel_vec[SEL_DHI];
assign wr_loc = wr_stb && sel_vec[SEL_LOC];
assign tick = tick_cnt_reg == TICK_CYC - 1;

////////////////////////////////////////////////////////////////////////////
// Enable registers
always @* begin
    en2_next = en2_reg;
    if (wr_en2) begin
        en2_next = wdata;
    end
end

always @* begin
    en3_next = en3_reg;
    if (wr_en3) begin
        en3_next = wdata[2:0];
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        en2_reg <= `LIRQ_RST_BYTE;
        en3_reg <= 3'h0;
    end else begin
        en2_reg <= en2_next;
        en3_reg <= en3_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// Sticky pending flags, set beats write-one clear
// Bits 10..3 status two, bits 2..0 status three
assign evt_all = {alarm_evt, calib_err_evt, done_pulse_reg,
    tone_detect_evt};
assign clr_all = wr_s2 ? {wdata, 3'h0} :
    (wr_s3 ? {8'h00, wdata[2:0]} :
    {NFLAG{1'b0}});
assign en_all = {en2_reg, en3_reg};

genvar gi;
generate
    for (gi = 0; gi < NFLAG; gi = gi + 1) begin : g_flag
        reg flag_reg;
        wire flag_next;
        assign flag_next = evt_all[gi] | (flag_reg & ~clr_all[gi]);
        always @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                flag_reg <= 1'b0;
            end else begin
                flag_reg <= flag_next;
            end
        end
        assign flag_all[gi] = flag_reg;
    end
endgenerate

assign gated_all = flag_all & en_all;
assign irq_n = ~(|gated_all);

////////////////////////////////////////////////////////////////////////////
// Update tick at 16 kHz
always @* begin
    if (tick) begin
        tick_cnt_next = 16'h0000;
    end else begin
        tick_cnt_next = tick_cnt_reg + 16'h0001;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        tick_cnt_reg <= 16'h0000;
    end else begin
        tick_cnt_reg <= tick_cnt_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// Indirect access port, one-hot request state
// An address rewrite while pending retargets the request
assign indirect_pending_flag = state_reg == ST_PEND;
assign complete = indirect_pending_flag && tick && !wr_loc;

always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (wr_loc) begin
                state_next = ST_PEND;
            end
        end
        ST_PEND: begin
            if (complete) begin
                state_next = ST_IDLE;
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        state_reg <= ST_IDLE;
    end else begin
        state_reg <= state_next;
    end
end

// Data written since last transfer marks a write
always @* begin
    dirty_next = dirty_reg;
    if (complete) begin
        dirty_next = 1'b0;
    end
    if (wr_lo || wr_hi) begin
        dirty_next = 1'b1;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        dirty_reg <= 1'b0;
    end else begin
        dirty_reg <= dirty_next;
    end
end

always @* begin
    indirect_data_word_next = indirect_data_word_reg;
    if (wr_lo) begin
        indirect_data_word_next[7:0] = wdata;
    end
    if (wr_hi) begin
        indirect_data_word_next[15:8] = wdata;
    end
    if (complete && !dirty_reg) begin
        indirect_data_word_next = ind_rdata;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        indirect_data_word_reg <= 16'h0000;
    end else begin
        indirect_data_word_reg <= indirect_data_word_next;
    end
end

always @* begin
    indirect_location_next = indirect_location_reg;
    if (wr_loc) begin
        indirect_location_next = wdata;
    end
end

// Undefined after reset in the device; zero here
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        indirect_location_reg <= `LIRQ_RST_BYTE;
    end else begin
        indirect_location_reg <= indirect_location_next;
    end
end

// Outgoing strobes, one cycle long, in the cycle after the completing tick
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ind_wr_stb <= 1'b0;
    end else begin
        ind_wr_stb <= complete && dirty_reg;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ind_rd_stb <= 1'b0;
    end else begin
        ind_rd_stb <= complete && !dirty_reg;
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ind_addr <= {AW{1'b0}};
    end else if (complete) begin
        ind_addr <= indirect_location_reg[AW-1:0];
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        ind_wdata <= 16'h0000;
    end else if (complete && dirty_reg) begin
        ind_wdata <= indirect_data_word_reg;
    end
end

// Done pulse rises the cycle after completion; the done flag is set one cycle later
always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        done_pulse_reg <= 1'b0;
    end else begin
        done_pulse_reg <= complete;
    end
end

////////////////////////////////////////////////////////////////////////////
// Read port, data one cycle after strobe
always @* begin
    rdata_next = 8'h00;
    if (sel_vec[SEL_S2]) begin
        rdata_next = flag_all[10:3];
    end else if (sel_vec[SEL_S3]) begin
        rdata_next = {5'h00, flag_all[2:0]};
    end else if (sel_vec[SEL_EN2]) begin
        rdata_next = en2_reg;
    end else if (sel_vec[SEL_EN3]) begin
        rdata_next = {5'h00, en3_reg};
    end else if (sel_vec[SEL_TONE]) begin
        rdata_next = {3'h0, digit_detect_flag, decoded_key_code};
    end else if (sel_vec[SEL_DLO]) begin
        rdata_next = indirect_data_word_reg[7:0];
    end else if (sel_vec[SEL_DHI]) begin
        rdata_next = indirect_data_word_reg[15:8];
    end else if (sel_vec[SEL_LOC]) begin
        rdata_next = indirect_location_reg;
    end else if (sel_vec[SEL_STATE]) begin
        rdata_next = {7'h00, indirect_pending_flag};
    end
end

always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
        rdata <= `LIRQ_RST_BYTE;
    end else if (rd_stb) begin
        rdata <= rdata_next;
    end
end

endmodule

//--- lirq_consts.vh
// Offsets, field positions, reset values and timing counts of the line irq bank
`ifndef LIRQ_CONSTS_VH
`define LIRQ_CONSTS_VH
`define LIRQ_OFF_STAT2 8'h13
`define LIRQ_OFF_STAT3 8'h14
`define LIRQ_OFF_EN2 8'h16
`define LIRQ_OFF_EN3 8'h17
`define LIRQ_OFF_TONE 8'h18
`define LIRQ_OFF_DLO 8'h1c
`define LIRQ_OFF_DHI 8'h1d
`define LIRQ_OFF_LOC 8'h1e
`define LIRQ_OFF_STATE 8'h1f
`define LIRQ_EN2_ALARM_HI 7
`define LIRQ_EN2_ALARM_LO 2
`define LIRQ_EN2_LOOP 1
`define LIRQ_EN2_RTRIP 0
`define LIRQ_EN3_CALIB 2
`define LIRQ_EN3_IND 1
`define LIRQ_EN3_TONE 0
`define LIRQ_TONE_VALID 4
`define LIRQ_RST_BYTE 8'h00
`define LIRQ_CLK_HZ 25000000
`define LIRQ_TICK_HZ 16000
`define LIRQ_TICK_CYC (`LIRQ_CLK_HZ / `LIRQ_TICK_HZ)
`endif

//--- lirq_bank_monitor.sv
// Checker of the line irq bank ports
`timescale 1ns/10ps
module lirq_mon #(parameter TICK_CYC = 8) (
    input wire clk_sys,
    input wire rstn,
    input wire [7:0] addr,
    input wire rd_stb,
    input wire wr_stb,
    input wire [7:0] rdata,
    input wire ind_wr_stb,
    input wire ind_rd_stb
);
    localparam int TW = TICK_CYC + 1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_en3; rd_stb && addr == 8'h17 |=> rdata[7:3] == 0; endproperty
    a_en3: assert property (p_en3) else $error("bad en3");
    property p_st; rd_stb && addr == 8'h1f |=> rdata[7:1] == 0; endproperty
    a_st: assert property (p_st) else $error("bad state");
    property p_tone; rd_stb && addr == 8'h18 |=> rdata[7:5] == 0; endproperty
    a_tone: assert property (p_tone) else $error("bad tone");
    property p_tick; wr_stb && addr == 8'h1e |=>
        ##[0:TW] (ind_wr_stb || ind_rd_stb); endproperty
    a_tick: assert property (p_tick) else $error("no tick");
    property p_wone; ind_wr_stb |=> !ind_wr_stb; endproperty
    a_wone: assert property (p_wone) else $error("long wr");
    property p_rone; ind_rd_stb |=> !ind_rd_stb; endproperty
    a_rone: assert property (p_rone) else $error("long rd");
    property p_excl; !(ind_wr_stb && ind_rd_stb); endproperty
    a_excl: assert property (p_excl) else $error("both strobes");
    property p_hold; !rd_stb |=> $stable(rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_um; rd_stb && addr == 8'h00 |=> rdata == 8'h00; endproperty
    a_um: assert property (p_um) else $error("unmapped read");
endmodule
bind lirq_bank lirq_mon #(.TICK_CYC(TICK_CYC)) u_mon (.clk_sys(clk_sys),
    .rstn(rstn), .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .rdata(rdata), .ind_wr_stb(ind_wr_stb), .ind_rd_stb(ind_rd_stb));

//--- tb.sv
// Self-checking bench of the line irq bank
`timescale 1ns/10ps
module tb;
    reg clk_sys = 0, rstn = 0, wr_stb = 0, rd_stb = 0, cal = 0, ton = 0;
    reg vf = 0;
    reg [3:0] kc = 0;
    reg [7:0] addr = 0, wdata = 0, ev = 0, s = 8'h57;
    reg [15:0] ird = 0, w = 0;
    wire [7:0] rdata, ia;
    wire iw, ir, irq_n;
    wire [15:0] iwd;
    integer err_total = 0, samples_checked = 0, i, b;
    always #20 clk_sys = ~clk_sys;
    lirq_bank #(.TICK_CYC(8)) uut (.clk_sys(clk_sys), .rstn(rstn),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .alarm_evt(ev), .calib_err_evt(cal),
        .tone_detect_evt(ton), .digit_detect_flag(vf),
        .decoded_key_code(kc), .ind_wr_stb(iw), .ind_rd_stb(ir),
        .ind_addr(ia), .ind_wdata(iwd), .ind_rdata(ird), .irq_n(irq_n));
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task chk(input [15:0] g, input [15:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            err_total = err_total + 1;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        #1;
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task wind;
        for (b = 0; b < 20 && iw !== 1'b1 && ir !== 1'b1; b = b + 1)
            @(posedge clk_sys) #1;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        err_total = err_total + 1;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(8'h1c, 8'h00);
        rdc(8'h00, 8'h00);
        for (i = 0; i < 16; i = i + 1) begin
            s = lfsr(s);
            @(posedge clk_sys);
            vf <= s[0];
            kc <= i[3:0];
            rdc(8'h18, {3'h0, s[0], i[3:0]});
            wr(8'h16, s);
            rdc(8'h16, s);
            wr(8'h17, s);
            rdc(8'h17, s & 8'h07);
        end
        wr(8'h17, 8'h00);
        w = s | 8'h01;
        @(posedge clk_sys);
        ev <= w[7:0];
        cal <= 1'b1;
        ton <= 1'b1;
        @(posedge clk_sys);
        ev <= 8'h00;
        cal <= 1'b0;
        ton <= 1'b0;
        for (b = 0; b < 8; b = b + 1) begin
            wr(8'h16, 8'h01 << b);
            chk(irq_n, !w[b]);
        end
        wr(8'h16, 8'h00);
        for (b = 0; b < 3; b = b + 1) begin
            wr(8'h17, 8'h01 << b);
            chk(irq_n, b == 1);
        end
        wr(8'h13, 8'hff);
        wr(8'h14, 8'hff);
        rdc(8'h13, 8'h00);
        wr(8'h17, 8'h07);
        chk(irq_n, 1'b1);
        w = {lfsr(s), s};
        wr(8'h1c, w[7:0]);
        wr(8'h1d, w[15:8]);
        wr(8'h1e, 8'h5a);
        wind;
        chk(iw, 1'b1);
        chk(ia, 8'h5a);
        chk(iwd, w);
        rdc(8'h14, 8'h02);
        chk(irq_n, 1'b0);
        ird <= ~w;
        wr(8'h1e, 8'ha5);
        rdc(8'h1f, 8'h01);
        wind;
        chk(ir, 1'b1);
        chk(ia, 8'ha5);
        rdc(8'h1c, ~w[7:0]);
        rdc(8'h1d, ~w[15:8]);
        rdc(8'h1f, 8'h00);
        wr(8'h1c, 8'h3c);
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1 chk(irq_n, 1'b1);
        rdc(8'h1c, 8'h00);
        end_sim;
    end
endmodule
